// ---- shared/fault_manager_consts.svh ----
// Register offsets, field positions, reset values and timing counts of the
// fault manager. Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef FAULT_MANAGER_CONSTS_SVH
`define FAULT_MANAGER_CONSTS_SVH

`define FM_ADDR_W         5
`define FM_OFS_CTRL       5'h00
`define FM_OFS_FB_MASK    5'h04
`define FM_OFS_STATUS     5'h08
`define FM_OFS_FB_VALUES  5'h0c
`define FM_OFS_AIN_FLAGS  5'h10
`define FM_OFS_CH_CFG     5'h14
`define FM_OFS_DEAD_TIME  5'h18
`define FM_OFS_WDG_PERIOD 5'h1c

`define FM_CTRL_CLEAR_BIT 0
`define FM_CTRL_CONN_BIT  1
`define FM_CTRL_RUN_BIT   2

`define FM_ST_LATCH_BIT   0
`define FM_ST_CONN_BIT    1
`define FM_ST_ILK_E_BIT   2
`define FM_ST_ILK_O_BIT   3
`define FM_ST_WDG_BIT     4
`define FM_ST_AIN_BIT     5
`define FM_ST_FB_BIT      6
`define FM_ST_STATE_LSB   8

`define FM_RST_FB_MASK    16'hffff
`define FM_RST_CH_CFG     32'h00000000
`define FM_RST_DEAD_TIME  16'h0000
`define FM_RST_WDG_PERIOD 24'h000000

// Watchdog timeout is period * 5 / 2
`define FM_WDG_MUL        3'h5

// Fault-to-block budget and the cycles it allows at 40 MHz
`define FM_BLOCK_MAX_NS   60
`define FM_CLK_PERIOD_NS  25
`define FM_BLOCK_CYCLES   (`FM_BLOCK_MAX_NS / `FM_CLK_PERIOD_NS)

`endif

// ---- shared/fault_manager_pkg.sv ----
// Types shared by the fault manager design and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package fault_manager_pkg;

	// Gray codes along blocked -> run -> fault
	typedef enum logic [1:0] {
		ST_BLOCKED = 2'b00,
		ST_RUN     = 2'b01,
		ST_FAULT   = 2'b11
	} exec_state_type;

	typedef enum logic [1:0] {
		CH_COMPLEMENTARY = 2'b00,
		CH_SWITCH_AUTH   = 2'b01,
		CH_INDEPENDENT   = 2'b10
	} channel_mode_type;

endpackage

`default_nettype wire

// ---- verilog/fault_manager_pwm_interlock.sv ----
// Fault supervision and PWM lane gating with dead time and interlocks.
// Assumes all inputs synchronous to i_clk_sys (40 MHz), Avalon-MM master.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`include "fault_manager_consts.svh"
`default_nettype none

// How it works
// - Each of the sixteen fault feedback lines can force the fault state.
// - Any analog input channel overvalue flag is a fault source.
// - Connector fault inputs are active low and disabled after reset.
// - Four connector fault inputs merge into one fault source.
// - Every connector fault output copies the interlock fault output.
// - Software mask enables each fault feedback line individually.
// - Software reads all collected fault values in status registers.
// - Watchdog timeout equals 2.5 times the programmed control period.
// - Watchdog faults when a full timeout passes without new data.
// - Fault manager owns execution state and gates all PWM lanes.
// - PWM lanes block within 60 ns of an active fault input.
// - Interlock reports internal faults out and accepts external faults.
// - Optical out lit without fault; unlit optical input means fault.
// - Fault feedback lanes are also readable as plain digital inputs.
// - Thirty-two lanes pair into sixteen channels with three modes.
// - Complementary mode gives high and low side with dead time.
// - Switch-plus-authorization mode: one switching lane, one enable lane.
// - Independent mode: own modulator per lane, no dead time.
// - Lanes 0 to 15 drive electrical and optical outputs identically.
// - Even lane is high side, odd lane is low side.
// - Dead time delays only rising edges, shortening each pulse.
module fault_manager_pwm_interlock
(
	// Clock, reset, enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	// Avalon-MM slave
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Fault sources
	input  wire logic [15:0] i_fault_feedback_lines,
	input  wire logic [15:0] i_analog_input_channel_over,
	input  wire logic        i_connector_a_fault_in_n,
	input  wire logic        i_connector_b_fault_in_n,
	input  wire logic        i_connector_c_fault_in_n,
	input  wire logic        i_connector_d_fault_in_n,
	input  wire logic        i_interlock_fault_in_n,
	input  wire logic        i_optical_interlock_in,
	input  wire logic        i_ctrl_data_strobe,
	// Interlock outputs
	output logic             o_interlock_fault_out_n,
	output logic      [3:0]  o_connector_fault_out_n,
	output logic             o_optical_interlock_out,
	// PWM lanes
	input  wire logic [31:0] i_pwm_modulator,
	output logic      [31:0] o_pwm_lane,
	output logic      [15:0] o_pwm_optical,
	// State
	output logic      [1:0]  o_exec_state
);

	function automatic logic [31:0] be_merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[b*8 +: 8] = new_val[b*8 +: 8];
		end
		return res;
	endfunction

	// Registers
	logic [15:0] fb_mask_reg;
	logic [31:0] ch_cfg_reg;
	logic [15:0] dead_time_reg;
	logic [23:0] wdg_period_reg;
	logic        conn_en_reg;
	logic        run_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [25:0] wdg_cnt_reg;
	logic        wdg_fault_reg;
	logic [31:0] pwm_reg;
	logic [15:0] dt_cnt_reg [32];
	logic [31:0] dt_done_reg;
	logic        ilk_out_n_reg;
	fault_manager_pkg::exec_state_type state_reg;
	fault_manager_pkg::exec_state_type state_next;

	// Bus decode: one wait cycle, answer at the second edge
	wire        bus_req   = i_avs_read | i_avs_write;
	wire        bus_done  = bus_req & ack_reg;
	wire        wr_en     = i_avs_write & bus_done & i_clk_en;
	wire [4:0]  ofs       = {i_avs_address[4:2], 2'b00};
	wire        wr_ctrl   = wr_en & (ofs == `FM_OFS_CTRL);
	wire        wr_mask   = wr_en & (ofs == `FM_OFS_FB_MASK);
	wire        wr_cfg    = wr_en & (ofs == `FM_OFS_CH_CFG);
	wire        wr_dt     = wr_en & (ofs == `FM_OFS_DEAD_TIME);
	wire        wr_wdg    = wr_en & (ofs == `FM_OFS_WDG_PERIOD);
	wire [31:0] ctrl_now  = {29'h0, run_reg, conn_en_reg, 1'b0};
	wire [31:0] ctrl_new  = be_merge(ctrl_now, i_avs_writedata,
		i_avs_byteenable);
	wire        clear_req = wr_ctrl & ctrl_new[`FM_CTRL_CLEAR_BIT];

	assign o_avs_waitrequest = bus_req & ~ack_reg;
	assign o_avs_readdata    = rdata_reg;

	// Fault collection
	wire fb_fault   = |(i_fault_feedback_lines & fb_mask_reg);
	wire ain_fault  = |i_analog_input_channel_over;
	wire conn_merge = ~(i_connector_a_fault_in_n &
		i_connector_b_fault_in_n & i_connector_c_fault_in_n &
		i_connector_d_fault_in_n);
	wire conn_fault = conn_en_reg & conn_merge;
	wire ilk_e_fault = ~i_interlock_fault_in_n;
	wire ilk_o_fault = ~i_optical_interlock_in;
	wire fault_now  = fb_fault | ain_fault | conn_fault |
		ilk_e_fault | ilk_o_fault | wdg_fault_reg;

	// Watchdog timeout of 2.5 periods; zero period disables it
	wire [25:0] wdg_limit = 26'((`FM_WDG_MUL * {2'b00, wdg_period_reg})
		>> 1);
	wire        wdg_on    = (wdg_period_reg != 24'h0);
	wire        wdg_hit   = wdg_on & (wdg_cnt_reg >= wdg_limit);

	// Execution state; a fault in the clear cycle wins over the clear
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			fault_manager_pkg::ST_BLOCKED:
				if (run_reg)
					state_next = fault_manager_pkg::ST_RUN;
			fault_manager_pkg::ST_RUN:
				if (!run_reg)
					state_next = fault_manager_pkg::ST_BLOCKED;
			fault_manager_pkg::ST_FAULT:
				if (clear_req)
					state_next = fault_manager_pkg::ST_BLOCKED;
			default:
				state_next = fault_manager_pkg::ST_FAULT;
		endcase
		if (fault_now)
			state_next = fault_manager_pkg::ST_FAULT;
	end

	// Lanes may only leave low in run state with no live fault
	wire gate_ok = (state_reg == fault_manager_pkg::ST_RUN) &
		~fault_now;

	// Per-channel lane requests
	logic [31:0] lane_req;
	logic [31:0] lane_dt;
	genvar ch;
	generate
		for (ch = 0; ch < 16; ch++)
		begin : g_ch
			wire [1:0] mode = ch_cfg_reg[2*ch +: 2];
			wire is_comp = (mode ==
				fault_manager_pkg::CH_COMPLEMENTARY);
			wire is_auth = (mode == fault_manager_pkg::CH_SWITCH_AUTH);
			wire hi      = i_pwm_modulator[2*ch];
			// Even lane is high side, odd lane low side
			assign lane_req[2*ch]   = hi;
			assign lane_req[2*ch+1] = is_comp ? ~hi :
				is_auth ? 1'b1 :
				i_pwm_modulator[2*ch+1];
			// Dead time only in complementary mode
			assign lane_dt[2*ch]   = is_comp;
			assign lane_dt[2*ch+1] = is_comp;
		end
	endgenerate

	// Delayed rising edge; falling edge passes at once
	logic [31:0] lane_out;
	always_comb
	begin
		for (int l = 0; l < 32; l++)
			lane_out[l] = lane_req[l] &
				(~lane_dt[l] | dt_done_reg[l]);
	end

	// Read mux, unmapped offsets read zero
	wire [31:0] status_word = {22'h0, state_reg, 1'b0, fb_fault,
		ain_fault, wdg_fault_reg, ilk_o_fault, ilk_e_fault,
		conn_fault, (state_reg == fault_manager_pkg::ST_FAULT)};
	wire [31:0] rd_mux =
		(ofs == `FM_OFS_CTRL)       ? ctrl_now :
		(ofs == `FM_OFS_FB_MASK)    ? {16'h0, fb_mask_reg} :
		(ofs == `FM_OFS_STATUS)     ? status_word :
		(ofs == `FM_OFS_FB_VALUES)  ? {16'h0, i_fault_feedback_lines} :
		(ofs == `FM_OFS_AIN_FLAGS)  ?
			{16'h0, i_analog_input_channel_over} :
		(ofs == `FM_OFS_CH_CFG)     ? ch_cfg_reg :
		(ofs == `FM_OFS_DEAD_TIME)  ? {16'h0, dead_time_reg} :
		(ofs == `FM_OFS_WDG_PERIOD) ? {8'h0, wdg_period_reg} :
		32'h0;

	// Bus and configuration
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			ack_reg        <= 1'b0;
			rdata_reg      <= 32'h0;
			fb_mask_reg    <= `FM_RST_FB_MASK;
			ch_cfg_reg     <= `FM_RST_CH_CFG;
			dead_time_reg  <= `FM_RST_DEAD_TIME;
			wdg_period_reg <= `FM_RST_WDG_PERIOD;
			conn_en_reg    <= 1'b0;
			run_reg        <= 1'b0;
		end
		else if (i_clk_en)
		begin
			ack_reg   <= bus_req & ~ack_reg;
			rdata_reg <= rd_mux;
			if (wr_ctrl)
			begin
				conn_en_reg <= ctrl_new[`FM_CTRL_CONN_BIT];
				run_reg     <= ctrl_new[`FM_CTRL_RUN_BIT];
			end
			if (wr_mask)
				fb_mask_reg <= 16'(be_merge({16'h0, fb_mask_reg},
					i_avs_writedata, i_avs_byteenable));
			if (wr_cfg)
				ch_cfg_reg <= be_merge(ch_cfg_reg, i_avs_writedata,
					i_avs_byteenable);
			if (wr_dt)
				dead_time_reg <= 16'(be_merge({16'h0, dead_time_reg},
					i_avs_writedata, i_avs_byteenable));
			if (wr_wdg)
				wdg_period_reg <= 24'(be_merge({8'h0, wdg_period_reg},
					i_avs_writedata, i_avs_byteenable));
		end
	end

	// Watchdog, state and outputs
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			wdg_cnt_reg   <= 26'h0;
			wdg_fault_reg <= 1'b0;
			state_reg     <= fault_manager_pkg::ST_BLOCKED;
			ilk_out_n_reg <= 1'b1;
			pwm_reg       <= 32'h0;
		end
		else if (i_clk_en)
		begin
			// Fault stays raised until fresh data arrives or the period is set to zero
			if (i_ctrl_data_strobe || !wdg_on)
			begin
				wdg_cnt_reg   <= 26'h0;
				wdg_fault_reg <= 1'b0;
			end
			else
			begin
				if (!wdg_hit)
					wdg_cnt_reg <= wdg_cnt_reg + 26'h1;
				if (wdg_hit)
					wdg_fault_reg <= 1'b1;
			end
			state_reg <= state_next;
			// Driven from next state so the outward flag tracks entry
			ilk_out_n_reg <= ~(state_next ==
				fault_manager_pkg::ST_FAULT);
			// Live fault gates here, one edge from input to low lanes
			pwm_reg <= gate_ok ? lane_out : 32'h0;
		end
	end

	// Dead-time counters: one per lane, reset whenever request is low
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			dt_done_reg <= 32'h0;
			for (int l = 0; l < 32; l++)
				dt_cnt_reg[l] <= 16'h0;
		end
		else if (i_clk_en)
		begin
			for (int l = 0; l < 32; l++)
			begin
				if (!lane_req[l])
				begin
					dt_cnt_reg[l]  <= 16'h0;
					dt_done_reg[l] <= 1'b0;
				end
				else if (dt_cnt_reg[l] >= dead_time_reg)
					dt_done_reg[l] <= 1'b1;
				else
					dt_cnt_reg[l] <= dt_cnt_reg[l] + 16'h1;
			end
		end
	end

	assign o_pwm_lane              = pwm_reg;
	assign o_pwm_optical           = pwm_reg[15:0];
	assign o_interlock_fault_out_n = ilk_out_n_reg;
	assign o_connector_fault_out_n = {4{ilk_out_n_reg}};
	assign o_optical_interlock_out = ilk_out_n_reg;
	assign o_exec_state            = state_reg;

endmodule

`default_nettype wire

// ---- sim/fault_manager_pwm_interlock_chk.sv ----
// Port checks of the fault manager.
// Assumes a bind to the top module; one clock domain.
`default_nettype none
module fault_manager_pwm_interlock_chk
(
	// Clock, reset, bus
	input wire logic        i_clk_sys,
	input wire logic        i_sys_rst,
	input wire logic        i_clk_en,
	input wire logic        i_avs_write,
	input wire logic        o_avs_waitrequest,
	// Faults
	input wire logic [15:0] i_analog_input_channel_over,
	input wire logic        i_interlock_fault_in_n,
	input wire logic        i_optical_interlock_in,
	input wire logic        o_interlock_fault_out_n,
	input wire logic [3:0]  o_connector_fault_out_n,
	input wire logic        o_optical_interlock_out,
	// Lanes and state
	input wire logic [31:0] o_pwm_lane,
	input wire logic [15:0] o_pwm_optical,
	input wire logic [1:0]  o_exec_state
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	wire logic fault_feedback_lines = o_exec_state == 2'h3;
	wire logic acc = i_avs_write & ~o_avs_waitrequest;
	sequence s_trip;
		i_clk_en && (!i_interlock_fault_in_n ||
			|i_analog_input_channel_over);
	endsequence
	sequence s_idle;
		o_exec_state == 2'h0 [*2];
	endsequence
	a_ext_trip: assert property (
		s_trip |=> fault_feedback_lines && o_pwm_lane == 32'h0)
		else $error("trip did not block lanes");
	a_dark_in: assert property (
		i_clk_en && !i_optical_interlock_in |=> !o_optical_interlock_out)
		else $error("dark input left output lit");
	a_ilk_mirror: assert property (o_interlock_fault_out_n == !fault_feedback_lines)
		else $error("interlock out disagrees with state");
	a_conn_copy: assert property (
		o_connector_fault_out_n == {4{o_interlock_fault_out_n}})
		else $error("connector out differs");
	a_opt_copy: assert property (o_pwm_optical == o_pwm_lane[15:0])
		else $error("optical lanes differ");
	a_fault_low: assert property (fault_feedback_lines |-> o_pwm_lane == 32'h0)
		else $error("lane high in fault");
	a_latch_hold: assert property (fault_feedback_lines && !acc |=> fault_feedback_lines)
		else $error("fault left without clear");
	a_idle_block: assert property (s_idle |-> o_pwm_lane == 32'h0)
		else $error("lane high while blocked");
endmodule
`default_nettype wire

// ---- sim/fault_partner_model.sv ----
// Far side: gate drivers, appliances, networked controller.
// Assumes trip commands from the bench; healthy after reset.
`default_nettype none
module fault_partner_model
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	// Trips: ilk, opt, conn[3:0]
	input  wire logic [5:0]  i_trip,
	input  wire logic [15:0] i_trip_fb,
	// Lines to the device
	output logic             o_ilk_n,
	output logic             o_opt,
	output logic      [3:0]  o_conn_n,
	output logic      [15:0] o_fb
);
	timeunit 1ns;
	timeprecision 1ps;
	// Healthy from time zero so no unknown source reaches the device
	initial
	begin
		{o_ilk_n, o_opt, o_conn_n, o_fb} = {6'h3f, 16'h0};
	end
	always @(posedge i_clk_sys)
	begin
		o_ilk_n <= i_sys_rst | ~i_trip[5];
		o_opt <= i_sys_rst | ~i_trip[4];
		o_conn_n <= ~(i_trip[3:0] & {4{~i_sys_rst}});
		o_fb <= i_trip_fb & {16{~i_sys_rst}};
	end
endmodule
`default_nettype wire

// ---- sim/fault_manager_pwm_interlock_bench.sv ----
// Bench: fault sources, latch, watchdog, lanes over the register bus.
// Assumes the partner model drives interlocks and feedback lines.
`include "fault_manager_consts.svh"
`default_nettype none
module fault_manager_pwm_interlock_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [15:0] fb;
		logic [15:0] analog_input_channel;
		logic [5:0]  trip;
		logic [9:0]  st;
	} row_type;
	row_type rows [7] = '{
		'{16'h8000, 16'h0, 6'h00, 10'h341},
		'{16'h0001, 16'h0, 6'h00, 10'h341},
		'{16'h0000, 16'h100, 6'h00, 10'h321},
		'{16'h0000, 16'h0, 6'h20, 10'h305},
		'{16'h0000, 16'h0, 6'h10, 10'h309},
		'{16'h0000, 16'h0, 6'h01, 10'h303},
		'{16'h0000, 16'h0, 6'h08, 10'h303}};
	logic [36:0] rv [5] = '{{5'h00, 32'h0}, {5'h04, 32'hffff},
		{5'h14, 32'h0}, {5'h18, 32'h0}, {5'h1c, 32'h0}};
	logic        clk, rst, rd, wr, stb, wreq, ilk_n, opt, ilk_o, opt_o;
	logic [4:0]  adr;
	logic [31:0] wdat, rdat, got, mod, lane;
	logic [15:0] analog_input_channel, tfb, fb;
	logic [5:0]  trip;
	logic [3:0]  conn_n, conn_o;
	logic [1:0]  state;
	int          fails, tests_run;
	fault_manager_pwm_interlock u_fault_manager_pwm_interlock (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(1'h1),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_fault_feedback_lines(fb), .i_analog_input_channel_over(analog_input_channel),
		.i_connector_a_fault_in_n(conn_n[0]),
		.i_connector_b_fault_in_n(conn_n[1]),
		.i_connector_c_fault_in_n(conn_n[2]),
		.i_connector_d_fault_in_n(conn_n[3]),
		.i_interlock_fault_in_n(ilk_n), .i_optical_interlock_in(opt),
		.i_ctrl_data_strobe(stb), .o_interlock_fault_out_n(ilk_o),
		.o_connector_fault_out_n(conn_o),
		.o_optical_interlock_out(opt_o), .i_pwm_modulator(mod),
		.o_pwm_lane(lane), .o_pwm_optical(), .o_exec_state(state));
	fault_partner_model u_fault_partner_model (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_trip(trip),
		.i_trip_fb(tfb), .o_ilk_n(ilk_n), .o_opt(opt),
		.o_conn_n(conn_n), .o_fb(fb));
	task automatic ck(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Pre-edge values are read right at each rising edge
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		logic busy;
		n = 0;
		busy = 1'h1;
		@(posedge clk);
		{adr, wdat, wr, rd} <= {a, d, w, ~w};
		while (busy)
		begin
			@(posedge clk);
			{busy, got} = {wreq, rdat};
			n++;
			if (n > 20)
			begin
				fails++;
				test_done();
			end
		end
		{wr, rd} <= 2'h0;
	endtask
	task automatic rearm(input string n);
		bus(1'h1, `FM_OFS_CTRL, 32'h7);
		t(2);
		@(negedge clk);
		ck("rearm", state, 2'h1);
		@(posedge clk);
		$display("test %s done", n);
	endtask
	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		{rst, rd, wr, stb, adr, wdat, mod, analog_input_channel, trip, tfb} = 1'h1 << 140;
		rst = 1'h1;
		{fails, tests_run} = 0;
		t(2);
		{rst, trip} <= {1'h0, 6'h01};
		t(3);
		@(negedge clk);
		ck("idle outs", {ilk_o, conn_o, opt_o, state}, 8'hfc);
		foreach (rv[i])
		begin
			bus(1'h0, rv[i][36:32], 32'h0);
			ck("reset reg", got, rv[i][31:0]);
		end
		trip <= 6'h0;
		rearm("reset");
		foreach (rows[i])
		begin
			{tfb, analog_input_channel, trip} <= {rows[i].fb, rows[i].analog_input_channel, rows[i].trip};
			t(3);
			bus(1'h0, `FM_OFS_STATUS, 32'h0);
			ck("status", got, {22'h0, rows[i].st});
			bus(1'h0, `FM_OFS_FB_VALUES, 32'h0);
			ck("raw lines", got, {16'h0, rows[i].fb});
			bus(1'h0, `FM_OFS_AIN_FLAGS, 32'h0);
			ck("analog flags", got, {16'h0, rows[i].analog_input_channel});
			bus(1'h1, `FM_OFS_CTRL, 32'h7);
			t(2);
			@(negedge clk);
			ck("refused clear", state, 2'h3);
			@(posedge clk);
			{tfb, analog_input_channel, trip} <= 38'h0;
			rearm("source");
		end
		bus(1'h1, `FM_OFS_FB_MASK, 32'hfffe);
		tfb <= 16'h1;
		t(3);
		@(negedge clk);
		ck("masked line", state, 2'h1);
		@(posedge clk);
		tfb <= 16'h0;
		t(2);
		bus(1'h1, `FM_OFS_FB_MASK, 32'hffff);
		bus(1'h1, `FM_OFS_WDG_PERIOD, 32'h4);
		repeat (6)
		begin
			@(posedge clk);
			stb <= 1'h1;
			@(posedge clk);
			stb <= 1'h0;
			t(7);
		end
		t(1);
		@(negedge clk);
		ck("fed timer", state, 2'h1);
		t(5);
		@(negedge clk);
		ck("starved timer", state, 2'h3);
		bus(1'h1, `FM_OFS_WDG_PERIOD, 32'h0);
		stb <= 1'h1;
		@(posedge clk);
		stb <= 1'h0;
		rearm("timer");
		bus(1'h1, `FM_OFS_DEAD_TIME, 32'h3);
		bus(1'h1, `FM_OFS_CH_CFG, 32'h24);
		mod <= 32'h34;
		t(8);
		@(negedge clk);
		ck("lanes on", lane[5:0], 6'h3e);
		@(posedge clk);
		mod <= 32'h1;
		t(2);
		@(negedge clk);
		ck("dead time", lane[5:0], 6'h08);
		t(5);
		@(negedge clk);
		ck("late rise", lane[5:0], 6'h09);
		@(posedge clk);
		tfb <= 16'h10;
		t(2);
		@(negedge clk);
		ck("blocked", lane, 32'h0);
		@(posedge clk);
		tfb <= 16'h0;
		rearm("lanes");
		test_done();
	end
endmodule
bind fault_manager_pwm_interlock fault_manager_pwm_interlock_chk u_chk (
	.i_clk_sys, .i_sys_rst, .i_clk_en, .i_avs_write, .o_avs_waitrequest,
	.i_analog_input_channel_over, .i_interlock_fault_in_n,
	.i_optical_interlock_in, .o_interlock_fault_out_n,
	.o_connector_fault_out_n, .o_optical_interlock_out, .o_pwm_lane,
	.o_pwm_optical, .o_exec_state);
`default_nettype wire
